/* rtl/mpc_regs.sv */
// Purpose: Memory-domain power cap, energy, range info and throttle-time registers
// Assumes: Power controller inputs are on ref_clk
// Notes: Read data appears one cycle after the read strobe with reg_ack
`timescale 1ns/10ps
module mpc_regs import mpc_pkg::*; #(
   parameter int MS_CYCLES_P = MS_CYCLES,
   parameter logic [14:0] INFO_TSP = INFO_TSP_DEF,
   parameter logic [14:0] INFO_MIN = INFO_MIN_DEF,
   parameter logic [14:0] INFO_MAX = INFO_MAX_DEF,
   parameter logic [5:0] INFO_WIN = INFO_WIN_DEF
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_sel,
   input wire logic [63:0] reg_wdata,
   output logic [63:0] reg_rdata,
   output logic reg_ack,
   input wire logic energy_valid,
   input wire logic [31:0] energy_delta,
   input wire logic time_unit_pulse,
   input wire logic limit_active,
   input wire logic [7:0] perf_requested,
   input wire logic [7:0] perf_granted,
   output logic [14:0] cap_power,
   output logic cap_enable,
   output logic [4:0] cap_window_exp,
   output logic [1:0] cap_window_frac,
   output logic cap_locked
);
   logic [31:0] cap_q;
   logic [31:0] energy_acc_q;
   logic [31:0] energy_q;
   logic [31:0] throttle_q;
   logic [63:0] rdata_q;
   logic ack_q;
   logic throttled;
   logic cap_wr;
   mpc_tick_if ms_if ();

   function automatic logic [63:0] info_word();
      info_word = {10'h0, INFO_WIN, 1'b0, INFO_MAX, 1'b0, INFO_MIN, 1'b0, INFO_TSP};
   endfunction

   mpc_ms_tick #(.CYCLES(MS_CYCLES_P)) u_tick (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .tk(ms_if.src)
   );

   assign cap_wr = reg_wr && (reg_sel == SEL_CAP) && !cap_q[CAP_LOCK_BIT];

   // Cap register, frozen once locked
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_q <= CAP_RESET;
      end else if (cap_wr) begin
         cap_q <= reg_wdata[31:0] & CAP_WRITE_MASK;
      end
   end

   assign cap_power = cap_q[CAP_POWER_MSB:CAP_POWER_LSB];
   assign cap_enable = cap_q[CAP_ENABLE_BIT];
   assign cap_window_exp = cap_q[WIN_EXP_MSB:WIN_EXP_LSB];
   assign cap_window_frac = cap_q[WIN_FRAC_MSB:WIN_FRAC_LSB];
   assign cap_locked = cap_q[CAP_LOCK_BIT];

   // Energy accumulation, published once per refresh period
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         energy_acc_q <= COUNT_RESET;
      end else if (energy_valid) begin
         energy_acc_q <= energy_acc_q + energy_delta;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         energy_q <= COUNT_RESET;
      end else if (ms_if.tick) begin
         energy_q <= energy_acc_q;
      end
   end

   // Throttled time counts only when the limit holds the granted state below the requested one
   assign throttled = time_unit_pulse && limit_active && (perf_granted < perf_requested);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         throttle_q <= COUNT_RESET;
      end else if (throttled) begin
         throttle_q <= throttle_q + 32'h1;
      end
   end

   // Read path
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 64'h0;
         ack_q <= 1'b0;
      end else begin
         ack_q <= reg_rd || reg_wr;
         if (reg_rd) begin
            if (reg_sel == SEL_CAP) begin
               rdata_q <= {32'h0, cap_q};
            end else if (reg_sel == SEL_ENERGY) begin
               rdata_q <= {32'h0, energy_q};
            end else if (reg_sel == SEL_INFO) begin
               rdata_q <= info_word();
            end else begin
               rdata_q <= {32'h0, throttle_q};
            end
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_ack = ack_q;

   // Cap register checks
   AST_LOCK_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cap_q[CAP_LOCK_BIT] && reg_wr && reg_sel == SEL_CAP) |=> $stable(cap_q))
      else $error("locked cap register changed on write");

   AST_LOCK_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cap_locked |=> cap_locked [*3])
      else $error("lock released without reset");

   AST_LOCK_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!cap_locked && reg_wr && reg_sel == SEL_CAP && reg_wdata[CAP_LOCK_BIT]) |=> cap_locked)
      else $error("lock bit not taken");

   AST_LOCK_FIELDS: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cap_locked |=> ($stable(cap_power) && $stable(cap_enable) && $stable(cap_window_exp)
      && $stable(cap_window_frac)))
      else $error("locked cap fields changed");

   AST_CAP_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!cap_q[CAP_LOCK_BIT] && reg_wr && reg_sel == SEL_CAP) |=>
      (cap_power == $past(reg_wdata[14:0]) && cap_enable == $past(reg_wdata[15])))
      else $error("cap write not taken");

   AST_ENABLE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!cap_locked && reg_wr && reg_sel == SEL_CAP && !reg_wdata[CAP_ENABLE_BIT]) |=> !cap_enable)
      else $error("cap not disabled by write of zero");

   AST_WINDOW_FIELDS: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!cap_q[CAP_LOCK_BIT] && reg_wr && reg_sel == SEL_CAP) |=>
      (cap_window_exp == $past(reg_wdata[21:17]) && cap_window_frac == $past(reg_wdata[23:22])))
      else $error("time window fields wrong");

   AST_NONCAP_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_sel != SEL_CAP) |=> $stable(cap_q))
      else $error("cap register changed by write to another register");

   // Counter checks
   AST_ENERGY_REFRESH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ms_if.tick |=> energy_q == $past(energy_acc_q))
      else $error("energy register not refreshed");

   AST_ENERGY_RO: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !ms_if.tick |=> $stable(energy_q))
      else $error("energy register changed between refreshes");

   AST_ENERGY_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      energy_valid |=> energy_acc_q == 32'($past(energy_acc_q) + $past(energy_delta)))
      else $error("energy accumulation wrong");

   AST_ENERGY_HOLD_ACC: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !energy_valid |=> $stable(energy_acc_q))
      else $error("energy total changed without a measurement");

   AST_THROTTLE_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_b)
      throttled |=> throttle_q == 32'($past(throttle_q) + 32'h1))
      else $error("throttle interval not counted");

   AST_THROTTLE_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!limit_active || perf_granted >= perf_requested) |=> $stable(throttle_q))
      else $error("throttle counted without limiting");

   AST_THROTTLE_NO_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !time_unit_pulse |=> $stable(throttle_q))
      else $error("throttle counted outside a time unit");

   // Read path checks
   AST_INFO_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_INFO) |=> (reg_ack && reg_rdata[53:48] == INFO_WIN
      && reg_rdata[46:32] == INFO_MAX && reg_rdata[30:16] == INFO_MIN && reg_rdata[14:0] == INFO_TSP))
      else $error("info register read wrong");

   AST_INFO_TSP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_INFO) |=> reg_rdata[14:0] == INFO_TSP)
      else $error("thermal power field wrong");

   AST_INFO_MIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_INFO) |=> reg_rdata[30:16] == INFO_MIN)
      else $error("minimum power field wrong");

   AST_INFO_MAX: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_INFO) |=> reg_rdata[46:32] == INFO_MAX)
      else $error("maximum power field wrong");

   AST_INFO_WIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_INFO) |=> reg_rdata[53:48] == INFO_WIN)
      else $error("maximum window field wrong");

   AST_INFO_RESERVED: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_INFO) |=> (reg_rdata[63:54] == 10'h0 && !reg_rdata[47]
      && !reg_rdata[31] && !reg_rdata[15]))
      else $error("info reserved bits not zero");

   AST_CAP_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_CAP) |=> (reg_ack && reg_rdata == {32'h0, $past(cap_q)}))
      else $error("cap register read wrong");

   AST_ENERGY_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_ENERGY) |=> (reg_ack && reg_rdata == {32'h0, $past(energy_q)}))
      else $error("energy register read wrong");

   AST_THROTTLE_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_sel == SEL_THROTTLE) |=> (reg_ack && reg_rdata == {32'h0, $past(throttle_q)}))
      else $error("throttle register read wrong");
endmodule

/* rtl/mpc_pkg.sv */
// Purpose: Constants for the memory-domain power cap register set
// Assumes: 125 MHz ref_clk; registers reached by model-specific register accesses
// Notes: Register selects are indices on the register access port
// What this block does
// - Cap register bits 14:0 hold the unsigned average power cap in power units.
// - Cap register bit 15 enables the cap when 1, disables it when 0.
// - Window bits 23:17 encode 2^Y*F; Y is bits 21:17, F tenths bits 23:22.
// - Once cap bit 31 is set, later cap writes are dropped until reset.
// - Energy register is read-only, refreshed with measured energy about every millisecond.
// - Energy bits 31:0 give total unsigned energy since last clear, energy units.
// - Read-only info register gives power range and largest programmable window.
// - Info bits 14:0 return thermal specification power in power units.
// - Info bits 30:16 return electrical minimum power in power units.
// - Info bits 46:32 return electrical maximum power in power units.
// - Info bits 53:48 return the largest acceptable time window value.
// - Throttle register bits 31:0 accumulate throttled time in time units, read-only.
// - Throttled time counts only when limits push below the requested performance state.
package mpc_pkg;
   localparam logic [1:0] SEL_CAP = 2'h0;
   localparam logic [1:0] SEL_ENERGY = 2'h1;
   localparam logic [1:0] SEL_INFO = 2'h2;
   localparam logic [1:0] SEL_THROTTLE = 2'h3;
   localparam int CAP_POWER_LSB = 0;
   localparam int CAP_POWER_MSB = 14;
   localparam int CAP_ENABLE_BIT = 15;
   localparam int WIN_EXP_LSB = 17;
   localparam int WIN_EXP_MSB = 21;
   localparam int WIN_FRAC_LSB = 22;
   localparam int WIN_FRAC_MSB = 23;
   localparam int CAP_LOCK_BIT = 31;
   localparam logic [31:0] CAP_WRITE_MASK = 32'h80fe_ffff;
   localparam logic [31:0] CAP_RESET = 32'h0000_0000;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [14:0] INFO_TSP_DEF = 15'h0000;
   localparam logic [14:0] INFO_MIN_DEF = 15'h0000;
   localparam logic [14:0] INFO_MAX_DEF = 15'h0000;
   localparam logic [5:0] INFO_WIN_DEF = 6'h00;
endpackage

/* rtl/mpc_tick_if.sv */
// Purpose: Carries the millisecond refresh pulse between design modules
// Assumes: Single clock domain
// Notes: One-cycle pulse
`timescale 1ns/10ps
interface mpc_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface

/* rtl/mpc_ms_tick.sv */
// Purpose: Divider giving a one-cycle pulse every refresh period
// Assumes: CYCLES at least 2
// Notes: First pulse CYCLES edges after reset release
`timescale 1ns/10ps
module mpc_ms_tick #(
   parameter int CYCLES = 125000
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   mpc_tick_if.src tk
);
   logic [31:0] cnt_q;
   logic tick_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (cnt_q == 32'(CYCLES - 1)) begin
         cnt_q <= 32'h0;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   assign tk.tick = tick_q;

   AST_TICK_SPACING: assert property (@(posedge ref_clk) disable iff (!rst_b) tick_q |=> !tick_q)
      else $error("refresh pulse longer than one cycle");
endmodule

/* test/mpc_regs_tb.sv */
// Purpose: Self-checking bench for the memory-domain power cap registers
// Assumes: Refresh period shortened to 8 cycles
// Notes: Bench drives every input of mpc_regs itself
`timescale 1ns/10ps
module mpc_regs_tb import mpc_pkg::*; ;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] reg_sel = 2'h0;
   logic [63:0] reg_wdata = 64'h0;
   logic [63:0] reg_rdata;
   logic reg_ack;
   logic energy_valid = 1'b0;
   logic [31:0] energy_delta = 32'h0;
   logic time_unit_pulse = 1'b0;
   logic limit_active = 1'b0;
   logic [7:0] perf_requested = 8'h0;
   logic [7:0] perf_granted = 8'h0;
   logic [14:0] cap_power;
   logic cap_enable;
   logic [4:0] cap_window_exp;
   logic [1:0] cap_window_frac;
   logic cap_locked;
   logic [63:0] rd_q;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   mpc_regs #(.MS_CYCLES_P(8), .INFO_TSP(15'h1234), .INFO_MIN(15'h0567), .INFO_MAX(15'h7abc),
      .INFO_WIN(6'h2d)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .energy_valid(energy_valid), .energy_delta(energy_delta), .time_unit_pulse(time_unit_pulse),
      .limit_active(limit_active), .perf_requested(perf_requested), .perf_granted(perf_granted),
      .cap_power(cap_power), .cap_enable(cap_enable), .cap_window_exp(cap_window_exp),
      .cap_window_frac(cap_window_frac), .cap_locked(cap_locked));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures = failures + 1;
         test_done();
      end
   end
   task automatic cmp(input string name, input logic [63:0] exp, input logic [63:0] got);
      checked = checked + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic tx(input logic wr, input logic [1:0] sel, input logic [63:0] d);
      @(posedge ref_clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_sel <= sel;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      rd_q = reg_rdata;
      cmp("reg_ack", 64'h1, {63'h0, reg_ack});
   endtask
   function automatic logic [63:0] fields();
      return {40'h0, cap_locked, cap_window_frac, cap_window_exp, cap_enable, cap_power};
   endfunction
   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
   endtask
   task automatic t_cap();
      tx(1'b1, SEL_CAP, 64'hffff_ffff_7fff_ffff);
      cmp("cap_fields", 64'h7f_ffff, fields());
      tx(1'b0, SEL_CAP, 64'h0);
      cmp("cap_read", 64'h00fe_ffff, rd_q);
      tx(1'b1, SEL_CAP, 64'h0052_4001);
      cmp("cap_fields", 64'h29_4001, fields());
      tx(1'b0, SEL_CAP, 64'h0);
      cmp("cap_read", 64'h0052_4001, rd_q);
   endtask
   task automatic t_info();
      tx(1'b1, SEL_INFO, 64'hffff_ffff_ffff_ffff);
      tx(1'b0, SEL_INFO, 64'h0);
      cmp("info_read", {10'h0, 6'h2d, 1'b0, 15'h7abc, 1'b0, 15'h0567, 1'b0, 15'h1234}, rd_q);
   endtask
   task automatic t_energy();
      @(posedge ref_clk);
      energy_valid <= 1'b1;
      energy_delta <= 32'hffff_fff0;
      @(posedge ref_clk);
      energy_delta <= 32'h0000_0025;
      @(posedge ref_clk);
      energy_valid <= 1'b0;
      repeat (20) @(posedge ref_clk);
      tx(1'b1, SEL_ENERGY, 64'hffff_ffff_ffff_ffff);
      tx(1'b0, SEL_ENERGY, 64'h0);
      cmp("energy_read", 64'h15, rd_q);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         time_unit_pulse <= 1'b1;
         @(posedge ref_clk);
         time_unit_pulse <= 1'b0;
      end
   endtask
   task automatic t_throttle();
      @(posedge ref_clk);
      limit_active <= 1'b1;
      perf_requested <= 8'h05;
      perf_granted <= 8'h03;
      pulses(3);
      perf_granted <= 8'h05;
      pulses(2);
      perf_granted <= 8'h03;
      limit_active <= 1'b0;
      pulses(2);
      tx(1'b1, SEL_THROTTLE, 64'hffff_ffff_ffff_ffff);
      tx(1'b0, SEL_THROTTLE, 64'h0);
      cmp("throttle_read", 64'h3, rd_q);
   endtask
   task automatic t_lock();
      tx(1'b1, SEL_CAP, 64'h8000_0123);
      tx(1'b1, SEL_CAP, 64'h0000_0456);
      tx(1'b0, SEL_CAP, 64'h0);
      cmp("locked_read", 64'h8000_0123, rd_q);
      cmp("cap_locked", 64'h1, {63'h0, cap_locked});
      @(posedge ref_clk);
      do_reset();
      tx(1'b0, SEL_CAP, 64'h0);
      cmp("reset_read", {32'h0, CAP_RESET}, rd_q);
      tx(1'b1, SEL_CAP, 64'h0000_0456);
      cmp("cap_fields", 64'h456, fields());
   endtask
   initial begin
      do_reset();
      t_energy();
      t_throttle();
      t_info();
      t_cap();
      t_lock();
      test_done();
   end
endmodule
